// ===== verilog/fcc_pkg.sv
package fcc_pkg;
  // channel count and bus widths
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // 1 us time base derived from the 100 MHz ref_clk
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = $clog2(TICK_CYC);
  // frequency sample windows in us, and one second in us
  localparam int US_PER_S = 1000000;
  localparam int WIN0_US = 1000000;
  localparam int WIN1_US = 100000;
  localparam int WIN2_US = 10000;
  localparam int WIN3_US = 1000;
  // per channel register block: addr[7:6]=0, addr[5:4]=channel, addr[3:0]=register
  localparam logic [1:0] REGION_CH = 2'h0;
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_LIMIT = 4'h4;
  localparam logic [3:0] REG_ACC = 4'h8;
  localparam logic [3:0] REG_STAMP = 4'hc;
  // global registers
  localparam logic [7:0] ADDR_PRG_RST = 8'h40;
  localparam logic [7:0] ADDR_GLOBAL = 8'h44;
  localparam logic [7:0] ADDR_LEVEL = 8'h48;
  localparam logic [7:0] ADDR_TIME = 8'h4c;
  // channel config fields
  localparam int CFG_W = 6;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_EDGE_BIT = 3;
  localparam int CFG_WIN_LSB = 4;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0000;
  localparam logic [3:0] PRG_RST_RESET = 4'h0;
  localparam int GLB_NEG_BIT = 0;
  // channel modes
  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_FREQ = 3'h1,
    MODE_TOTAL = 3'h2,
    MODE_PULSE = 3'h3,
    MODE_QUAD = 3'h4,
    MODE_TOT_RESET = 3'h5
  } fcc_mode_e;
endpackage

// ===== verilog/fcc_edge.sv
module fcc_edge (
  // clock and reset
  input logic ref_clk,
  input logic resetn,
  // raw pin
  input logic pin,
  // synchronised level and edge pulses
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta; // first stage, read only by sync
  logic sync; // second stage
  logic prev; // previous sample for edge compare

  // two flop synchroniser plus one history flop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // edges come from successive synchronised samples only
  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;

  sync_rise_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rise |-> $past(pin, 2) && !$past(pin, 3))
    else $error("rise pulse without matching pin history");
endmodule

// ===== verilog/fcc_counter.sv
module fcc_counter #(
  parameter int WIN0 = fcc_pkg::WIN0_US,
  parameter int WIN1 = fcc_pkg::WIN1_US,
  parameter int WIN2 = fcc_pkg::WIN2_US,
  parameter int WIN3 = fcc_pkg::WIN3_US
) (
  // clock and reset
  input logic ref_clk,
  input logic resetn,
  // counter input pins
  input logic [fcc_pkg::NUM_CH-1:0] count_pin,
  // register port
  input logic [fcc_pkg::ADDR_W-1:0] addr,
  input logic [fcc_pkg::DATA_W-1:0] wr_data,
  input logic wr_en,
  input logic rd_en,
  output logic [fcc_pkg::DATA_W-1:0] rd_data
);
  import fcc_pkg::*;

  logic [CFG_W-1:0] cfg [NUM_CH]; // mode, edge, window per channel
  logic [31:0] limit [NUM_CH]; // wrap limit per channel
  logic [31:0] measurement_input_register [NUM_CH]; // accumulators
  logic [31:0] stamp [NUM_CH]; // us time of last counted edge
  logic [31:0] fcnt [NUM_CH]; // edges seen in current window
  logic [31:0] wcnt [NUM_CH]; // us elapsed in current window
  logic [3:0] program_reset_bits; // level resets from the program
  logic neg_logic; // inputs read as on when low
  logic [TICK_W-1:0] tick_cnt; // cycles within one us
  logic tick; // one cycle pulse per us
  logic [31:0] us_time; // free running us count
  logic [NUM_CH-1:0] level; // synchronised pin levels
  logic [NUM_CH-1:0] rise; // synchronised rising edges
  logic [NUM_CH-1:0] fall; // synchronised falling edges
  logic [NUM_CH-1:0] count_edge; // configured edge per channel
  logic [NUM_CH-1:0] hw_hit; // hardware reset strike per channel
  logic hw_reset_input_a; // input three edge aimed at channel one
  logic hw_reset_input_b; // input four edge aimed at channel two
  logic [1:0] wr_ch; // channel addressed by the bus
  logic [2:0] wr_mode; // mode field of the write data
  logic [31:0] next_rd; // read mux result
  logic [31:0] win_len [NUM_CH]; // selected window in us
  logic [31:0] win_scale [NUM_CH]; // windows per second

  assign wr_ch = addr[5:4];
  assign wr_mode = wr_data[CFG_MODE_LSB +: 3];

  // 1 us time base; frequency windows and edge time stamps are quantised to this tick
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == TICK_W'(TICK_CYC - 1));

  // microsecond clock used for edge time stamps
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      us_time <= 32'h0000_0000;
    end else if (tick) begin
      us_time <= us_time + 32'h0000_0001;
    end
  end

  tick_period_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    tick |-> ##1 !tick ##99 tick)
    else $error("time base tick not every 100 cycles");

  // channel configuration and wrap limits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg[i] <= CFG_RESET;
        limit[i] <= LIMIT_RESET;
      end
    end else if (wr_en && addr[7:6] == REGION_CH) begin
      if (addr[3:0] == REG_CFG) begin
        // reset type only once the target channel already totalizes
        if (wr_mode == MODE_TOT_RESET &&
            !(wr_ch[1] && cfg[{1'b0, wr_ch[0]}][2:0] == MODE_TOTAL)) begin
          cfg[wr_ch] <= {wr_data[CFG_W-1:3], MODE_OFF};
        end else begin
          cfg[wr_ch] <= wr_data[CFG_W-1:0];
        end
      end else if (addr[3:0] == REG_LIMIT) begin
        limit[wr_ch] <= wr_data;
      end
    end
  end

  // program reset bits and global polarity
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      program_reset_bits <= PRG_RST_RESET;
      neg_logic <= 1'b0;
    end else if (wr_en && addr == ADDR_PRG_RST) begin
      program_reset_bits <= wr_data[3:0];
    end else if (wr_en && addr == ADDR_GLOBAL) begin
      neg_logic <= wr_data[GLB_NEG_BIT];
    end
  end

  // hardware reset sources; the reset channel's own edge bit picks polarity
  assign hw_reset_input_a = cfg[2][2:0] == MODE_TOT_RESET && count_edge[2];
  assign hw_reset_input_b = cfg[3][2:0] == MODE_TOT_RESET && count_edge[3];
  assign hw_hit[0] = hw_reset_input_a && cfg[0][2:0] == MODE_TOTAL;
  assign hw_hit[1] = hw_reset_input_b && cfg[1][2:0] == MODE_TOTAL;
  // only the first two channels have a reset partner; the upper two never strike
  assign hw_hit[3:2] = 2'b00;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // pin synchroniser and edge detector
      fcc_edge u_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pin(count_pin[g]),
        .level(level[g]),
        .rise(rise[g]),
        .fall(fall[g])
      );

      // edge select works on the uninverted synchronised pin, so it ignores neg_logic;
      // negative logic users must pick the opposite edge
      assign count_edge[g] = cfg[g][CFG_EDGE_BIT] ? fall[g] : rise[g];

      // window choice trades update rate against resolution
      always_comb begin
        case (cfg[g][CFG_WIN_LSB +: 2])
          2'h0: win_len[g] = 32'(WIN0);
          2'h1: win_len[g] = 32'(WIN1);
          2'h2: win_len[g] = 32'(WIN2);
          default: win_len[g] = 32'(WIN3);
        endcase
        win_scale[g] = 32'(US_PER_S) / win_len[g];
      end

      // window timer and edge count for frequency mode
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          wcnt[g] <= 32'h0000_0000;
          fcnt[g] <= 32'h0000_0000;
        end else if (cfg[g][2:0] != MODE_FREQ) begin
          wcnt[g] <= 32'h0000_0000;
          fcnt[g] <= 32'h0000_0000;
        end else if (tick && wcnt[g] >= win_len[g] - 32'h0000_0001) begin
          // window closes: restart, keeping an edge that lands now
          wcnt[g] <= 32'h0000_0000;
          fcnt[g] <= {31'h0, rise[g]};
        end else begin
          wcnt[g] <= tick ? wcnt[g] + 32'h0000_0001 : wcnt[g];
          fcnt[g] <= fcnt[g] + {31'h0, rise[g]};
        end
      end

      // accumulator: program reset, hardware reset, totalize, frequency
      // a held program bit outranks a hardware strike landing in the same cycle
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          measurement_input_register[g] <= 32'h0000_0000;
        end else if (program_reset_bits[g] && cfg[g][2:0] == MODE_TOTAL) begin
          measurement_input_register[g] <= 32'h0000_0000;
        end else if (hw_hit[g]) begin
          // cleared three cycles after the pin edge, far inside 100 us
          measurement_input_register[g] <= 32'h0000_0000;
        end else if (cfg[g][2:0] == MODE_TOTAL && count_edge[g]) begin
          if (limit[g] != 32'h0000_0000 &&
              measurement_input_register[g] == limit[g] - 32'h0000_0001) begin
            measurement_input_register[g] <= 32'h0000_0000;
          end else begin
            // zero limit rolls over naturally at the top of 32 bits
            measurement_input_register[g] <= measurement_input_register[g] + 32'h1;
          end
        end else if (cfg[g][2:0] == MODE_FREQ && tick &&
                     wcnt[g] >= win_len[g] - 32'h0000_0001) begin
          measurement_input_register[g] <= 32'(fcnt[g] * win_scale[g]);
        end
      end

      // time stamp of the last counted edge at 1 us resolution
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          stamp[g] <= 32'h0000_0000;
        end else if (cfg[g][2:0] != MODE_OFF && count_edge[g]) begin
          stamp[g] <= us_time;
        end
      end

      prog_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        program_reset_bits[g] && cfg[g][2:0] == MODE_TOTAL
        |=> measurement_input_register[g] == 32'h0000_0000)
        else $error("program reset did not hold accumulator at zero");

      tot_inc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg[g][2:0] == MODE_TOTAL && count_edge[g] && !program_reset_bits[g] &&
        !hw_hit[g] && limit[g] == 32'h0000_0000
        |=> measurement_input_register[g] == $past(measurement_input_register[g]) + 32'h1)
        else $error("totalizer did not count edge");

      wrap_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg[g][2:0] == MODE_TOTAL && count_edge[g] && !program_reset_bits[g] &&
        limit[g] != 32'h0000_0000 &&
        measurement_input_register[g] == limit[g] - 32'h0000_0001
        |=> measurement_input_register[g] == 32'h0000_0000)
        else $error("totalizer did not wrap at limit");

      full_range_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg[g][2:0] == MODE_TOTAL && limit[g] == 32'h0000_0000 &&
        measurement_input_register[g] != 32'hffff_ffff && count_edge[g] &&
        !program_reset_bits[g] && !hw_hit[g]
        |=> measurement_input_register[g] != 32'h0000_0000)
        else $error("zero limit wrapped early");

      freq_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg[g][2:0] == MODE_FREQ && tick && wcnt[g] >= win_len[g] - 32'h1
        |=> measurement_input_register[g] == 32'($past(fcnt[g]) * $past(win_scale[g])))
        else $error("frequency result not loaded at window end");

      // a counted edge records the microsecond in which it was seen
      edge_stamp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg[g][2:0] != MODE_OFF && count_edge[g]
        |=> stamp[g] == $past(us_time))
        else $error("edge time stamp not taken");
    end
  endgenerate

  hw_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg[0][2:0] == MODE_TOTAL && cfg[2][2:0] == MODE_TOT_RESET && count_edge[2]
    |=> measurement_input_register[0] == 32'h0000_0000)
    else $error("hardware reset missed totalizer one");

  hw_edge_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    hw_reset_input_b |=> !hw_reset_input_b)
    else $error("hardware reset acted as a level");

  // the second reset input clears totalizer two one cycle after its edge
  hw_clear_b_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg[1][2:0] == MODE_TOTAL && hw_reset_input_b
    |=> measurement_input_register[1] == 32'h0000_0000)
    else $error("hardware reset missed totalizer two");

  // a reset type request sets the channel to MODE_OFF while its target is not totalizing
  tot_reset_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == {REGION_CH, 2'h2, REG_CFG} && wr_data[2:0] == MODE_TOT_RESET &&
    cfg[0][2:0] != MODE_TOTAL
    |=> cfg[2][2:0] == MODE_OFF)
    else $error("reset type accepted without a totalizing target");

  // read mux over channel and global registers
  always_comb begin
    next_rd = 32'h0000_0000;
    if (addr[7:6] == REGION_CH) begin
      if (addr[3:0] == REG_CFG) begin
        next_rd = {26'h0, cfg[wr_ch]};
      end else if (addr[3:0] == REG_LIMIT) begin
        next_rd = limit[wr_ch];
      end else if (addr[3:0] == REG_ACC) begin
        next_rd = measurement_input_register[wr_ch];
      end else if (addr[3:0] == REG_STAMP) begin
        next_rd = stamp[wr_ch];
      end
    end else if (addr == ADDR_PRG_RST) begin
      next_rd = {28'h0, program_reset_bits};
    end else if (addr == ADDR_GLOBAL) begin
      next_rd = {31'h0, neg_logic};
    end else if (addr == ADDR_LEVEL) begin
      next_rd = {28'h0, level ^ {NUM_CH{neg_logic}}};
    end else if (addr == ADDR_TIME) begin
      next_rd = us_time;
    end
  end

  // read data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_en ? next_rd : 32'h0000_0000;
    end
  end

  rd_acc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == {REGION_CH, 2'h1, REG_ACC}
    |=> rd_data == $past(measurement_input_register[1]))
    else $error("accumulator read returned wrong value");
endmodule

// ===== tb/fcc_pulse_src.sv
module fcc_pulse_src #(
  parameter int GAP = 10000
) (
  // clock the sources are paced by
  input wire logic ref_clk,
  // pins toward the counter inputs
  output logic [fcc_pkg::NUM_CH-1:0] count_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import fcc_pkg::*;

  // all sources idle low until a scenario asks for edges
  initial begin
    count_pin = '0;
  end

  // n full pulses on one pin; each level held GAP cycles so edges never crowd
  // caller enters right after a rising edge, so the period is exactly 2*GAP
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      count_pin[ch] <= 1'b1;
      repeat (GAP) @(posedge ref_clk);
      count_pin[ch] <= 1'b0;
      repeat (GAP) @(posedge ref_clk);
    end
  endtask

  // one level change, then hold it for the minimum spacing
  task automatic level(input int ch, input logic v);
    count_pin[ch] <= v;
    repeat (GAP) @(posedge ref_clk);
  endtask
endmodule

// ===== tb/test_fcc_counter.sv
module test_fcc_counter;
  timeunit 1ns;
  timeprecision 100ps;
  import fcc_pkg::*;

  // edge spacing scaled down like the windows, 100 us would make the run too long
  localparam int GAP = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [NUM_CH-1:0] count_pin;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic rd_seen = 1'b0; // a read was taken at the last edge
  logic [DATA_W-1:0] last_rd = '0; // latest result, for relative checks
  logic [DATA_W-1:0] exp_q[$]; // expected read results, oldest first
  bit any_q[$]; // set where any value is accepted
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h1570;
  logic [31:0] lim;
  int n;

  fcc_counter #(.WIN0(100), .WIN1(50), .WIN2(20), .WIN3(10)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .count_pin(count_pin), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  fcc_pulse_src #(.GAP(GAP)) src_u (.ref_clk(ref_clk), .count_pin(count_pin));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // next value of the stimulus shift register
  function automatic logic [31:0] fcc_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // channel register address
  function automatic logic [7:0] fcc_reg(input int c, input logic [3:0] r);
    return {REGION_CH, 2'(c), r};
  endfunction

  // one bus cycle; a read notes its expected result, an idle cycle follows
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input bit any = 1'b0);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= ~w;
    addr <= a;
    wr_data <= d;
    if (!w) begin
      exp_q.push_back(d);
      any_q.push_back(any);
    end
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  // compare one value
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read data must show only in the cycle after the strobe, zero otherwise
  always @(posedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      if (!any_q.pop_front()) begin
        check("rd_data", exp_q.pop_front(), rd_data);
      end else begin
        void'(exp_q.pop_front());
      end
      last_rd = rd_data;
    end else if (resetn) begin
      // before the first reset edge the read register is still unknown
      check("rd_data idle", '0, rd_data);
    end
    rd_seen <= rd_en;
  end

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (50000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    // every channel register starts at zero
    for (int c = 0; c < NUM_CH; c++) begin
      for (int r = 0; r < 16; r += 4) begin
        bus(1'b0, fcc_reg(c, r[3:0]), '0);
      end
    end
    bus(1'b1, 8'h80, 32'hffff_ffff);
    bus(1'b0, 8'h80, '0);
    // reset mode refused while its target is not totalizing
    bus(1'b1, fcc_reg(2, REG_CFG), 32'h5);
    bus(1'b0, fcc_reg(2, REG_CFG), '0);
    // negative logic inverts the level readback only
    bus(1'b1, ADDR_GLOBAL, 32'h1);
    bus(1'b0, ADDR_LEVEL, 32'hf);
    // random wrap limit and edge count, rising edges on channel 0
    seed = fcc_lfsr(seed);
    lim = 32'h3 + {30'h0, seed[1:0]};
    n = 7 + int'(seed[4:2]);
    bus(1'b1, fcc_reg(0, REG_LIMIT), lim);
    bus(1'b1, fcc_reg(0, REG_CFG), 32'h2);
    src_u.pulse(0, n);
    bus(1'b0, fcc_reg(0, REG_ACC), 32'(n) % lim);
    bus(1'b0, fcc_reg(0, REG_LIMIT), lim);
    // falling edges on channel 1, zero limit
    bus(1'b1, fcc_reg(1, REG_CFG), 32'ha);
    src_u.pulse(1, 3);
    src_u.level(1, 1'b1);
    bus(1'b0, fcc_reg(1, REG_ACC), 32'h3);
    src_u.level(1, 1'b0);
    bus(1'b0, fcc_reg(1, REG_ACC), 32'h4);
    // program reset holds channel 0 at zero while set
    bus(1'b1, ADDR_PRG_RST, 32'h1);
    src_u.pulse(0, 2);
    bus(1'b0, fcc_reg(0, REG_ACC), '0);
    bus(1'b1, ADDR_PRG_RST, 32'h0);
    src_u.pulse(0, 2);
    bus(1'b0, fcc_reg(0, REG_ACC), 32'h2);
    // hardware resets: ch2 rising clears ch0, ch3 falling clears ch1
    bus(1'b1, fcc_reg(2, REG_CFG), 32'h5);
    bus(1'b0, fcc_reg(2, REG_CFG), 32'h5);
    bus(1'b1, fcc_reg(3, REG_CFG), 32'hd);
    src_u.level(2, 1'b1);
    bus(1'b0, fcc_reg(0, REG_ACC), '0);
    src_u.level(3, 1'b1);
    bus(1'b0, fcc_reg(1, REG_ACC), 32'h4);
    src_u.level(3, 1'b0);
    bus(1'b0, fcc_reg(1, REG_ACC), '0);
    src_u.level(2, 1'b0);
    // frequency on ch3, 10 us window, 25 rising edges per window
    bus(1'b1, fcc_reg(3, REG_CFG), 32'h31);
    fork
      src_u.pulse(3, 75);
      begin
        repeat (2500) @(posedge ref_clk);
        bus(1'b0, fcc_reg(3, REG_ACC), 32'(25 * (US_PER_S / 10)));
      end
    join
    // time base advances one per microsecond, 100 cycles apart
    bus(1'b0, ADDR_TIME, '0, 1'b1);
    repeat (998) @(posedge ref_clk);
    bus(1'b0, ADDR_TIME, last_rd + 32'd10);
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule
